// ==== hw/aef_framer.sv ====
// Host-bound announce, heartbeat and sensor event message framer, top level
//
// Overview of operation
// - Frame opens 0xFB, then length of rest
// - Announcements carry type 0x27, status byte 3
// - Short announcement length 2; startup A0, sync A1
// - Short codes: bad argument E1, read-only E4
// - Short codes: brownout EC, watchdog ED, hardware EE
// - Join: length 6, A3, net, parent MAC
// - Exit: length 3, A4, exited net id
// - Heartbeat: length 0x0C, A8, own/parent MACs
// - Heartbeat parent net; own net or 0xFF
// - Beacon power averaged 1/16, 127 invalid
// - Heartbeat byte 0x0D parent received power
// - Sensor event report: length 0x12, type 0x28
// - Event byte 6 signed received power
// - Event byte 7 general input levels
// - Three 12-bit readings from 0x08, low first
// - Flag word bits 0-3 input triggers
// - Flag bit 4 periodic, 5-7 thresholds
// - Flag word upper byte always zero
// - Two 12-bit settings at 0x10, 0x12
`timescale 1ns/1ps
module aef_framer #(
   parameter int ALPHA_SHIFT = 4
) (
   input  wire logic                clk_sys_in,
   input  wire logic                rst_n_in,
   input  wire logic                req_valid_in,
   output logic                     req_ready_out,
   input  wire aef_pkg::aef_req_t   req_in,
   input  wire logic                bcn_valid_in,
   input  wire logic          [7:0] bcn_pwr_in,
   output logic                     tx_valid_out,
   input  wire logic                tx_ready_in,
   output logic               [7:0] tx_data_out,
   output logic                     tx_sof_out,
   output logic                     tx_eof_out
);

   // Only a shift of four gives the required smoothing factor
   if (ALPHA_SHIFT != 4) begin : g_bad_alpha
      $error("ALPHA_SHIFT must give a 0.0625 smoothing factor");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State

   aef_pkg::aef_state_t             state;
   aef_pkg::aef_state_t             next_state;
   logic [aef_pkg::IDX_W-1:0]       idx;
   logic [aef_pkg::IDX_W-1:0]       next_idx;
   aef_pkg::aef_req_t               msg;
   aef_pkg::aef_req_t               next_msg;
   logic                      [7:0] bcn_lat;
   logic                      [7:0] next_bcn_lat;
   logic                      [7:0] next_tx_data;
   logic                            tx_last;
   logic                            next_tx_last;
   logic                      [7:0] bcn_avg;
   logic                      [7:0] sel_byte;
   logic                            sel_last;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   aef_beacon_avg #(
      .ALPHA_SHIFT (ALPHA_SHIFT)
   ) u_bcn (
      .clk_sys_in   (clk_sys_in),
      .rst_n_in     (rst_n_in),
      .smp_valid_in (bcn_valid_in),
      .smp_pwr_in   (bcn_pwr_in),
      .avg_out      (bcn_avg)
   );

   // Looks ahead at the next offset so the byte register is ready on entry
   aef_frame_sel u_sel (
      .msg_in   (next_msg),
      .bcn_in   (next_bcn_lat),
      .idx_in   (next_idx),
      .byte_out (sel_byte),
      .last_out (sel_last)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      next_state   = state;
      next_idx     = idx;
      next_msg     = msg;
      next_bcn_lat = bcn_lat;
      case (state)
         aef_pkg::AEF_IDLE: begin
            // Message and averaged power are frozen for the whole frame
            if (req_valid_in) begin
               next_state   = aef_pkg::AEF_SEND;
               next_idx     = aef_pkg::OFF_SOP;
               next_msg     = req_in;
               next_bcn_lat = bcn_avg;
            end
         end
         aef_pkg::AEF_SEND: begin
            if (tx_ready_in) begin
               if (tx_last) begin
                  next_state = aef_pkg::AEF_IDLE;
               end else begin
                  next_idx = idx + 5'h01;
               end
            end
         end
         default: begin
            next_state = aef_pkg::AEF_IDLE;
         end
      endcase
      next_tx_data = sel_byte;
      next_tx_last = sel_last;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state       <= aef_pkg::AEF_IDLE;
         idx         <= aef_pkg::RST_IDX;
         msg         <= '0;
         bcn_lat     <= aef_pkg::PWR_INVALID;
         tx_data_out <= aef_pkg::RST_BYTE;
         tx_last     <= 1'b0;
      end else begin
         state       <= next_state;
         idx         <= next_idx;
         msg         <= next_msg;
         bcn_lat     <= next_bcn_lat;
         tx_data_out <= next_tx_data;
         tx_last     <= next_tx_last;
      end
   end

   // New request only taken between frames, so two never mix
   assign req_ready_out = (state == aef_pkg::AEF_IDLE);
   assign tx_valid_out  = (state == aef_pkg::AEF_SEND);
   assign tx_sof_out    = tx_valid_out && (idx == aef_pkg::OFF_SOP);
   assign tx_eof_out    = tx_valid_out && tx_last;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic                      beat;
   logic [aef_pkg::IDX_W-1:0] beat_cnt;
   logic                [7:0] len_seen;
   logic                      is_short;
   logic                      is_event;

   assign beat     = tx_valid_out && tx_ready_in;
   assign is_short = (msg.kind == aef_pkg::AEF_K_SHORT);
   assign is_event = (msg.kind == aef_pkg::AEF_K_EVENT);

   // Independent count of accepted bytes and the length byte that went out
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         beat_cnt <= aef_pkg::RST_IDX;
         len_seen <= aef_pkg::RST_BYTE;
      end else if (beat) begin
         beat_cnt <= tx_eof_out ? aef_pkg::RST_IDX : beat_cnt + 5'h01;
         if (idx == aef_pkg::OFF_LEN) begin
            len_seen <= tx_data_out;
         end
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   sop_first_a:
   assert property ($rose(tx_valid_out) |-> tx_sof_out && tx_data_out == aef_pkg::SOP)
      else $error("frame does not open with start byte");

   len_count_a:
   assert property (beat && tx_eof_out |-> {3'b000, beat_cnt} == len_seen + 8'h01)
      else $error("length byte disagrees with bytes sent");

   ann_type_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_TYPE && !is_event
                    |-> tx_data_out == aef_pkg::TYPE_ANN)
      else $error("announcement type byte wrong");

   short_len_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_LEN && is_short
                    |-> tx_data_out == aef_pkg::LEN_SHORT)
      else $error("short announcement length wrong");

   short_code_a:
   assert property (beat && idx == aef_pkg::OFF_TYPE && is_short
                    |=> tx_data_out == msg.stat && tx_eof_out)
      else $error("short status code or end wrong");

   join_net_a:
   assert property (beat && idx == aef_pkg::OFF_STAT && msg.kind == aef_pkg::AEF_K_JOIN
                    |-> tx_data_out == aef_pkg::AEF_ST_JOINED ##1
                        (tx_data_out == msg.net_id) [*1])
      else $error("join status or network byte wrong");

   exit_len_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_LEN
                    && msg.kind == aef_pkg::AEF_K_EXIT
                    |-> tx_data_out == aef_pkg::LEN_EXIT)
      else $error("exit length wrong");

   hb_mac_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_HB_MAC
                    && msg.kind == aef_pkg::AEF_K_HBEAT
                    |-> tx_data_out == msg.own_mac[7:0])
      else $error("heartbeat own address low byte wrong");

   hb_router_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_HB_OWN
                    && msg.kind == aef_pkg::AEF_K_HBEAT
                    |-> tx_data_out == (msg.is_router ? msg.own_net : aef_pkg::NOT_ROUTER))
      else $error("heartbeat router network byte wrong");

   hb_beacon_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_HB_BCN
                    && msg.kind == aef_pkg::AEF_K_HBEAT
                    |-> tx_data_out == bcn_lat)
      else $error("heartbeat beacon power wrong");

   ev_mac_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_EV_MAC && is_event
                    |-> tx_data_out == msg.peer_mac[7:0])
      else $error("event originator address wrong");

   flag_hi_a:
   assert property (beat && idx == aef_pkg::OFF_EV_FLAG && is_event
                    |=> tx_data_out == 8'h00)
      else $error("flag word upper byte not zero");

   dac1_lo_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_EV_DAC1 && is_event
                    |-> tx_data_out == msg.dac1[7:0])
      else $error("second output setting low byte wrong");

   hold_byte_a:
   assert property (tx_valid_out && !tx_ready_in
                    |=> tx_valid_out && $stable(tx_data_out) && $stable(idx))
      else $error("byte changed while stalled");

   no_mix_a:
   assert property (beat && tx_eof_out |=> !tx_valid_out ##1 1'b1)
      else $error("frame ran on past its last byte");

   exit_net_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_NET && msg.kind == aef_pkg::AEF_K_EXIT
                    |-> tx_data_out == msg.net_id)
      else $error("exit network byte wrong");

   hb_parent_a:
   assert property (tx_valid_out && tx_eof_out && msg.kind == aef_pkg::AEF_K_HBEAT
                    |-> tx_data_out == msg.parent_pwr && idx == aef_pkg::OFF_HB_BCN + 5'h01)
      else $error("heartbeat parent power byte wrong");

   ev_type_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_TYPE && is_event
                    |-> tx_data_out == aef_pkg::TYPE_EVENT)
      else $error("event type byte wrong");

   ev_rssi_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_EV_MAC + 5'h03 && is_event
                    |-> tx_data_out == msg.rssi)
      else $error("event received power byte wrong");

   ev_gpio_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_EV_MAC + 5'h04 && is_event
                    |-> tx_data_out == 8'(msg.gpio_lvl))
      else $error("event input levels byte wrong");

   ev_flags_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_EV_FLAG && is_event
                    |-> tx_data_out == msg.flags)
      else $error("event flag byte wrong");

   short_end_a:
   assert property (tx_valid_out && idx == aef_pkg::OFF_STAT && is_short
                    |-> tx_eof_out)
      else $error("short announcement does not end at status");

   ev_end_a:
   assert property (tx_valid_out && tx_eof_out && is_event
                    |-> idx == aef_pkg::OFF_EV_DAC1 + 5'h01 && tx_data_out == 8'(msg.dac1[11:8]))
      else $error("event last byte wrong");

   short_done_c:
   cover property (beat && tx_eof_out && is_short);

   hb_done_c:
   cover property (beat && tx_eof_out && msg.kind == aef_pkg::AEF_K_HBEAT);

   ev_stall_c:
   cover property (tx_valid_out && !tx_ready_in && is_event ##1 beat);

   ev_done_c:
   cover property (beat && tx_eof_out && is_event);

endmodule

// ==== hw/aef_pkg.sv ====
// Constants, codes and carrier types for the announce and event message framer
package aef_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Frame geometry
   localparam int         FRAME_BYTES = 20;
   localparam int         FRAME_W     = 8 * FRAME_BYTES;
   localparam int         IDX_W       = 5;
   localparam int         GPIO_W      = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed header bytes and lengths
   localparam logic [7:0] SOP         = 8'hFB;
   localparam logic [7:0] TYPE_ANN    = 8'h27;
   localparam logic [7:0] TYPE_EVENT  = 8'h28;
   localparam logic [7:0] LEN_SHORT   = 8'h02;
   localparam logic [7:0] LEN_JOIN    = 8'h06;
   localparam logic [7:0] LEN_EXIT    = 8'h03;
   localparam logic [7:0] LEN_HBEAT   = 8'h0C;
   localparam logic [7:0] LEN_EVENT   = 8'h12;
   localparam logic [7:0] NOT_ROUTER  = 8'hFF;
   localparam logic [7:0] PWR_INVALID = 8'h7F;
   localparam logic [7:0] PWR_TOP     = 8'h7E;

   ////////////////////////////////////////////////////////////////////////////
   // Byte offsets within a frame
   localparam logic [IDX_W-1:0] OFF_SOP     = 5'h00;
   localparam logic [IDX_W-1:0] OFF_LEN     = 5'h01;
   localparam logic [IDX_W-1:0] OFF_TYPE    = 5'h02;
   localparam logic [IDX_W-1:0] OFF_STAT    = 5'h03;
   localparam logic [IDX_W-1:0] OFF_NET     = 5'h04;
   localparam logic [IDX_W-1:0] OFF_HB_MAC  = 5'h04;
   localparam logic [IDX_W-1:0] OFF_HB_OWN  = 5'h0B;
   localparam logic [IDX_W-1:0] OFF_HB_BCN  = 5'h0C;
   localparam logic [IDX_W-1:0] OFF_EV_MAC  = 5'h03;
   localparam logic [IDX_W-1:0] OFF_EV_FLAG = 5'h0E;
   localparam logic [IDX_W-1:0] OFF_EV_DAC1 = 5'h12;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [IDX_W-1:0] RST_IDX  = 5'h00;
   localparam logic [7:0]       RST_BYTE = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Message kinds and status codes
   typedef enum logic [2:0] {
      AEF_K_SHORT = 3'b000,
      AEF_K_JOIN  = 3'b001,
      AEF_K_EXIT  = 3'b010,
      AEF_K_HBEAT = 3'b011,
      AEF_K_EVENT = 3'b100
   } aef_kind_t;

   typedef enum logic [7:0] {
      AEF_ST_STARTUP  = 8'hA0,
      AEF_ST_FASTSYNC = 8'hA1,
      AEF_ST_JOINED   = 8'hA3,
      AEF_ST_EXITED   = 8'hA4,
      AEF_ST_HBEAT    = 8'hA8,
      AEF_ST_BAD_ARG  = 8'hE1,
      AEF_ST_RO_WRITE = 8'hE4,
      AEF_ST_BROWNOUT = 8'hEC,
      AEF_ST_WATCHDOG = 8'hED,
      AEF_ST_HW_FAIL  = 8'hEE
   } aef_stat_t;

   typedef enum logic [0:0] {
      AEF_IDLE = 1'b0,
      AEF_SEND = 1'b1
   } aef_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [2:0] adc_thr;
      logic       periodic;
      logic [3:0] gpio_trig;
   } aef_flags_t;

   typedef struct packed {
      aef_kind_t         kind;
      aef_stat_t         stat;
      logic [7:0]        net_id;
      logic [23:0]       peer_mac;
      logic [23:0]       own_mac;
      logic [7:0]        own_net;
      logic              is_router;
      logic [7:0]        parent_pwr;
      logic [7:0]        rssi;
      logic [GPIO_W-1:0] gpio_lvl;
      logic [11:0]       adc0;
      logic [11:0]       adc1;
      logic [11:0]       adc2;
      aef_flags_t        flags;
      logic [11:0]       dac0;
      logic [11:0]       dac1;
   } aef_req_t;

   // Twelve-bit reading as a little endian byte pair
   function automatic logic [15:0] aef_le12(input logic [11:0] v);
      aef_le12 = {4'h0, v};
   endfunction

endpackage

// ==== hw/aef_beacon_avg.sv ====
// Running average of received beacon power with a shift-based smoothing filter
`timescale 1ns/1ps
module aef_beacon_avg #(
   parameter int ALPHA_SHIFT = 4
) (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       smp_valid_in,
   input  wire logic [7:0] smp_pwr_in,
   output logic      [7:0] avg_out
);

   localparam int ACC_W = 8 + ALPHA_SHIFT;

   // Wider shifts would need a wider accumulator than is worth keeping
   if (ALPHA_SHIFT < 1 || ALPHA_SHIFT > 8) begin : g_bad_shift
      $error("ALPHA_SHIFT out of range");
   end

   logic signed [ACC_W-1:0] acc;
   logic signed [ACC_W-1:0] next_acc;
   logic                    seen;
   logic                    next_seen;
   logic             [7:0]  next_avg;
   logic signed [ACC_W-1:0] smp_scaled;
   logic signed [ACC_W:0]   diff;

   ////////////////////////////////////////////////////////////////////////////
   // Invalid samples are skipped so they cannot drag the average up
   always_comb begin
      smp_scaled = {smp_pwr_in, {ALPHA_SHIFT{1'b0}}};
      diff       = {smp_scaled[ACC_W-1], smp_scaled} - {acc[ACC_W-1], acc};
      next_acc   = acc;
      next_seen  = seen;
      if (smp_valid_in && smp_pwr_in != aef_pkg::PWR_INVALID) begin
         next_seen = 1'b1;
         if (seen) begin
            next_acc = acc + ACC_W'(diff >>> ALPHA_SHIFT);
         end else begin
            next_acc = smp_scaled;
         end
      end
      next_avg = next_acc[ACC_W-1:ALPHA_SHIFT];
      if (!next_seen) begin
         next_avg = aef_pkg::PWR_INVALID;
      end else if (next_avg == aef_pkg::PWR_INVALID) begin
         next_avg = aef_pkg::PWR_TOP;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc     <= '0;
         seen    <= 1'b0;
         avg_out <= aef_pkg::PWR_INVALID;
      end else begin
         acc     <= next_acc;
         seen    <= next_seen;
         avg_out <= next_avg;
      end
   end

endmodule

// ==== hw/aef_frame_sel.sv ====
// Lays out one message as a byte image and picks the byte at a given offset
`timescale 1ns/1ps
module aef_frame_sel (
   input  wire aef_pkg::aef_req_t                msg_in,
   input  wire logic             [7:0]           bcn_in,
   input  wire logic [aef_pkg::IDX_W-1:0]        idx_in,
   output logic                  [7:0]           byte_out,
   output logic                                  last_out
);

   logic [aef_pkg::FRAME_W-1:0] frame;
   logic [7:0]                  len;
   logic [7:0]                  own_net;

   // Image is built lowest offset in the lowest bits, so fields land little endian
   always_comb begin
      frame   = '0;
      len     = aef_pkg::LEN_SHORT;
      own_net = msg_in.is_router ? msg_in.own_net : aef_pkg::NOT_ROUTER;
      case (msg_in.kind)
         aef_pkg::AEF_K_JOIN: begin
            len          = aef_pkg::LEN_JOIN;
            frame[63:0]  = {msg_in.peer_mac, msg_in.net_id, aef_pkg::AEF_ST_JOINED,
                            aef_pkg::TYPE_ANN, len, aef_pkg::SOP};
         end
         aef_pkg::AEF_K_EXIT: begin
            len          = aef_pkg::LEN_EXIT;
            frame[39:0]  = {msg_in.net_id, aef_pkg::AEF_ST_EXITED,
                            aef_pkg::TYPE_ANN, len, aef_pkg::SOP};
         end
         aef_pkg::AEF_K_HBEAT: begin
            len          = aef_pkg::LEN_HBEAT;
            frame[111:0] = {msg_in.parent_pwr, bcn_in, own_net, msg_in.net_id,
                            msg_in.peer_mac, msg_in.own_mac, aef_pkg::AEF_ST_HBEAT,
                            aef_pkg::TYPE_ANN, len, aef_pkg::SOP};
         end
         aef_pkg::AEF_K_EVENT: begin
            len          = aef_pkg::LEN_EVENT;
            frame        = {aef_pkg::aef_le12(msg_in.dac1),
                            aef_pkg::aef_le12(msg_in.dac0),
                            8'h00, msg_in.flags,
                            aef_pkg::aef_le12(msg_in.adc2),
                            aef_pkg::aef_le12(msg_in.adc1),
                            aef_pkg::aef_le12(msg_in.adc0),
                            {(8 - aef_pkg::GPIO_W){1'b0}}, msg_in.gpio_lvl,
                            msg_in.rssi, msg_in.peer_mac,
                            aef_pkg::TYPE_EVENT, len, aef_pkg::SOP};
         end
         default: begin
            frame[31:0]  = {msg_in.stat, aef_pkg::TYPE_ANN,
                            len, aef_pkg::SOP};
         end
      endcase
      byte_out = frame[{idx_in, 3'b000} +: 8];
      last_out = ({3'b000, idx_in} == len + 8'h01);
   end

endmodule

// ==== test/aef_host_model.sv ====
// Host-side receiver model that accepts framer bytes and records them with markers
`timescale 1ns/1ps
module aef_host_model (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       slow_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_sof_in,
   input  wire logic       tx_eof_in,
   output logic            tx_ready_out
);
   logic [9:0] rx_q[$];
   logic [9:0] held;
   logic       pend;
   logic [1:0] stall_cnt;
   int         hold_err;

   initial begin
      tx_ready_out = 1'b0;
      pend = 1'b0;
      stall_cnt = 2'h0;
      hold_err = 0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slow mode accepts one cycle in four, so every byte after a frame's first is held a while
   always @(negedge clk_sys_in) begin
      stall_cnt <= stall_cnt + 2'h1;
      tx_ready_out <= rst_n_in && (!slow_in || stall_cnt == 2'h3);
   end

   ////////////////////////////////////////////////////////////////////////////
   // A byte that is offered but not yet taken must not change
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pend = 1'b0;
      end else if (tx_valid_in === 1'b1) begin
         if (pend && held !== {tx_sof_in, tx_eof_in, tx_data_in}) begin
            hold_err++;
         end
         if (tx_ready_out) begin
            rx_q.push_back({tx_sof_in, tx_eof_in, tx_data_in});
            pend = 1'b0;
         end else begin
            held = {tx_sof_in, tx_eof_in, tx_data_in};
            pend = 1'b1;
         end
      end
   end
endmodule

// ==== test/tb_aef_framer.sv ====
// Self-checking bench for the announce, heartbeat and sensor event framer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_aef_framer;
   logic              clk_sys_in;
   logic              rst_n_in;
   logic              req_valid_in;
   logic              req_ready_out;
   aef_pkg::aef_req_t req_in;
   aef_pkg::aef_req_t r;
   logic              bcn_valid_in;
   logic        [7:0] bcn_pwr_in;
   logic              tx_valid_out;
   logic              tx_ready_in;
   logic        [7:0] tx_data_out;
   logic              tx_sof_out;
   logic              tx_eof_out;
   logic              slow;
   logic        [7:0] cur_q[$];
   logic        [9:0] exp_q[$];
   logic        [7:0] sc[7] = '{8'hA0, 8'hA1, 8'hE1, 8'hE4, 8'hEC, 8'hED, 8'hEE};
   int                failures = 0;
   int                checks_done = 0;
   int                cycles = 0;

   aef_framer #(.ALPHA_SHIFT(4)) u_dut (
      .clk_sys_in    (clk_sys_in),
      .rst_n_in      (rst_n_in),
      .req_valid_in  (req_valid_in),
      .req_ready_out (req_ready_out),
      .req_in        (req_in),
      .bcn_valid_in  (bcn_valid_in),
      .bcn_pwr_in    (bcn_pwr_in),
      .tx_valid_out  (tx_valid_out),
      .tx_ready_in   (tx_ready_in),
      .tx_data_out   (tx_data_out),
      .tx_sof_out    (tx_sof_out),
      .tx_eof_out    (tx_eof_out)
   );

   aef_host_model u_host (
      .clk_sys_in   (clk_sys_in),
      .rst_n_in     (rst_n_in),
      .slow_in      (slow),
      .tx_valid_in  (tx_valid_out),
      .tx_data_in   (tx_data_out),
      .tx_sof_in    (tx_sof_out),
      .tx_eof_in    (tx_eof_out),
      .tx_ready_out (tx_ready_in)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timeout: the whole run needs well under two thousand cycles
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Expected frames are built byte by byte, markers added on close
   task automatic put(input logic [7:0] b);
      cur_q.push_back(b);
   endtask
   task automatic put12(input logic [11:0] v);
      put(v[7:0]);
      put({4'h0, v[11:8]});
   endtask
   task automatic put24(input logic [23:0] v);
      put(v[7:0]);
      put(v[15:8]);
      put(v[23:16]);
   endtask
   task automatic close;
      foreach (cur_q[i]) exp_q.push_back({i == 0, i == cur_q.size() - 1, cur_q[i]});
      cur_q.delete();
   endtask

   // Request held from a falling edge until the edge that takes it
   task automatic send;
      @(negedge clk_sys_in);
      req_in = r;
      req_valid_in = 1'b1;
      while (req_ready_out !== 1'b1) @(negedge clk_sys_in);
      @(negedge clk_sys_in);
      req_valid_in = 1'b0;
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (u_host.rx_q.size() < exp_q.size() && n < 3000) begin
         @(negedge clk_sys_in);
         n++;
      end
      repeat (4) @(negedge clk_sys_in);
      `CHK(u_host.rx_q.size(), exp_q.size())
      foreach (exp_q[i]) if (i < u_host.rx_q.size()) `CHK(u_host.rx_q[i], exp_q[i])
      `CHK(u_host.hold_err, 0)
      exp_q.delete();
      u_host.rx_q.delete();
   endtask

   task automatic bcn(input logic [7:0] p);
      @(negedge clk_sys_in);
      bcn_valid_in = 1'b1;
      bcn_pwr_in = p;
      @(negedge clk_sys_in);
      bcn_valid_in = 1'b0;
   endtask

   task automatic hb(input logic router, input logic [7:0] avg);
      r = '0;
      r.kind = aef_pkg::AEF_K_HBEAT;
      r.own_mac = 24'hA1_B2C3;
      r.peer_mac = 24'h44_5566;
      r.net_id = 8'h21;
      r.own_net = 8'h37;
      r.is_router = router;
      r.parent_pwr = 8'h80;
      send();
      put(8'hFB); put(8'h0C); put(8'h27); put(8'hA8); put24(24'hA1_B2C3);
      put24(24'h44_5566); put(8'h21); put(router ? 8'h37 : 8'hFF);
      put(avg); put(8'h80);
      close();
   endtask

   task automatic ev(input logic [7:0] rssi, input logic [5:0] gpio, input logic [11:0] a0,
                     input logic [11:0] a1, input logic [11:0] a2, input logic [3:0] trig,
                     input logic per, input logic [2:0] thr, input logic [11:0] d0,
                     input logic [11:0] d1);
      r = '0;
      r.kind = aef_pkg::AEF_K_EVENT;
      r.peer_mac = 24'h9E_8D7C;
      r.rssi = rssi;
      r.gpio_lvl = gpio;
      r.adc0 = a0;
      r.adc1 = a1;
      r.adc2 = a2;
      r.flags.gpio_trig = trig;
      r.flags.periodic = per;
      r.flags.adc_thr = thr;
      r.dac0 = d0;
      r.dac1 = d1;
      send();
      put(8'hFB); put(8'h12); put(8'h28); put24(24'h9E_8D7C);
      put(rssi); put({2'b00, gpio});
      put12(a0); put12(a1); put12(a2);
      put({thr, per, trig}); put(8'h00);
      put12(d0); put12(d1);
      close();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n_in = 1'b0;
      req_valid_in = 1'b0;
      req_in = '0;
      bcn_valid_in = 1'b0;
      bcn_pwr_in = 8'h00;
      slow = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      `CHK(req_ready_out, 1'b1)
      `CHK(tx_valid_out, 1'b0)
      rst_n_in = 1'b1;
      // Every short code back to back with a prompt host
      for (int i = 0; i < 7; i++) begin
         r = '0;
         r.kind = aef_pkg::AEF_K_SHORT;
         r.stat = aef_pkg::aef_stat_t'(sc[i]);
         send();
         put(8'hFB); put(8'h02); put(8'h27); put(sc[i]);
         close();
      end
      // Undefined kind codes fall back to the short frame
      r.kind = aef_pkg::aef_kind_t'(3'b101);
      send();
      put(8'hFB); put(8'h02); put(8'h27); put(8'hEE);
      close();
      drain();
      // Join and exit with a stalling host
      slow = 1'b1;
      r = '0;
      r.kind = aef_pkg::AEF_K_JOIN;
      r.net_id = 8'h5C;
      r.peer_mac = 24'h12_3456;
      send();
      put(8'hFB); put(8'h06); put(8'h27); put(8'hA3); put(8'h5C); put24(24'h12_3456);
      close();
      r.kind = aef_pkg::AEF_K_EXIT;
      r.net_id = 8'hC5;
      send();
      put(8'hFB); put(8'h03); put(8'h27); put(8'hA4); put(8'hC5);
      close();
      drain();
      // Beacon average: invalid first, then load, then one filter step
      hb(1'b0, 8'h7F);
      drain();
      bcn(8'h7F);
      bcn(8'hD8);
      hb(1'b1, 8'hD8);
      bcn(8'hE8);
      hb(1'b1, 8'hD9);
      drain();
      // Sensor event reports at field extremes and mixed patterns
      slow = 1'b0;
      ev(8'h7F, 6'h3F, 12'hFFF, 12'hFFF, 12'hFFF, 4'hF, 1'b1, 3'h7, 12'hFFF, 12'hFFF);
      slow = 1'b1;
      ev(8'h80, 6'h15, 12'h000, 12'h9A5, 12'h0F0, 4'h5, 1'b0, 3'h6, 12'h123, 12'hE0D);
      drain();
      end_sim();
   end
endmodule
